/* shared/ibs_pkg.sv */
// Functional notes
// - tx empty irq = tx buffer empty flag and its enable.
// - tx end irq = tx complete flag and its enable.
// - rx full irq = rx buffer full flag and its enable.
// - stop irq = stop flag and stop irq enable.
// - one shared irq for no-ack or arbitration lost, gated by no-ack enable.
// - master advances bits only in step with real scl level.
// - scl monitored after release for 7.5/19.5/17.5/41.5 tcyc per clock select.
// - reset into module stop; registers other than stop accessible only after stop cleared.
// - master receive: scl held low if rx full at eighth falling edge.
// - read near eighth fall: hold only one clock, then release; data may be lost.
// - noise canceler passes a sample only when two cascaded latches agree.
package ibs_pkg;
   // register offsets
   localparam logic [3:0] ADDR_STOP   = 4'h0;  // module stop control
   localparam logic [3:0] ADDR_CTRL   = 4'h1;  // bus control and clock select
   localparam logic [3:0] ADDR_STATUS = 4'h2;  // bus status flags
   localparam logic [3:0] ADDR_IRQEN  = 4'h3;  // per-request enables
   localparam logic [3:0] ADDR_RXDATA = 4'h4;  // rx data register
   localparam logic [3:0] ADDR_BUSB   = 4'h5;  // bus control b (scl monitor)
   localparam logic [3:0] ADDR_EVST   = 4'h6;  // sticky event status
   localparam logic [3:0] ADDR_EVCLR  = 4'h7;  // event clear (write only)
   localparam logic [3:0] ADDR_EVEN   = 4'h8;  // event enable
   localparam logic [3:0] ADDR_TXDATA = 4'h9;  // tx data (clears tx empty)
   // control register field positions
   localparam int CTL_MST  = 0;
   localparam int CTL_TRS  = 1;
   localparam int CTL_RX_CONTINUE_DISABLE = 2;
   localparam int CTL_CLOCK_SELECT_BIT2 = 3;
   localparam int CTL_CLOCK_SELECT_BIT3 = 4;
   // status / enable bit positions
   localparam int ST_TX_BUFFER_EMPTY_FLAG  = 0;
   localparam int ST_TX_COMPLETE_FLAG  = 1;
   localparam int ST_RX_BUFFER_FULL_FLAG  = 2;
   localparam int ST_STOP  = 3;
   localparam int ST_NACK  = 4;
   localparam int ST_AL    = 5;
   localparam int NUM_EV   = 5;
   localparam logic [7:0] STATUS_RST = 8'h01;
   localparam logic [4:0] CTRL_RST   = 5'h00;
   // scl monitor times in tenths of tcyc
   localparam int MON_T00 = 75;
   localparam int MON_T01 = 195;
   localparam int MON_T10 = 175;
   localparam int MON_T11 = 415;
   localparam int BITS_PER_BYTE = 8;
   localparam int HALF_BIT_CYC  = 25;    // half scl period in sys clocks
   typedef enum logic [2:0]
   {
      IBS_IDLE  = 3'b000,
      IBS_LOW   = 3'b001,
      IBS_MON   = 3'b010,
      IBS_HIGH  = 3'b011,
      IBS_HOLD  = 3'b100
   } ibs_state_t;
   // monitor count in whole sys clocks, least time rounds up
   function automatic logic [5:0] ibs_mon_cycles(input logic [1:0] cks);
      int t;
      begin
         t = (cks == 2'b00) ? MON_T00 : (cks == 2'b01) ? MON_T01 :
             (cks == 2'b10) ? MON_T10 : MON_T11;
         ibs_mon_cycles = 6'((t + 9) / 10);
      end
   endfunction : ibs_mon_cycles
endpackage : ibs_pkg

/* hdl/ibs_filter.sv */
`timescale 1ns/1ns
// two-flop sync plus agreement filter for one bus line
module ibs_filter
   import ibs_pkg::*;
(
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic raw_in,
   output logic      clean_out
);
   logic sync_a;
   logic sync_b;
   logic latch_a;
   logic latch_b;
   // synchroniser, first flop read only by second
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
      end
      else
      begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end
   // cascaded latches and match detector
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         latch_a   <= 1'b1;
         latch_b   <= 1'b1;
         clean_out <= 1'b1;
      end
      else
      begin
         latch_a <= sync_b;
         latch_b <= latch_a;
         if (latch_a == latch_b)
            clean_out <= latch_b;
      end
   end
endmodule : ibs_filter

/* hdl/ibs_irq.sv */
`timescale 1ns/1ns
// request levels from flags and enables
module ibs_irq
   import ibs_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic [7:0] flags_in,
   input  wire logic [4:0] enables_in,
   output logic [4:0]      req_out
);
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         req_out <= '0;
      else
      begin
         req_out[0] <= flags_in[ST_TX_BUFFER_EMPTY_FLAG] & enables_in[ST_TX_BUFFER_EMPTY_FLAG];
         req_out[1] <= flags_in[ST_TX_COMPLETE_FLAG] & enables_in[ST_TX_COMPLETE_FLAG];
         req_out[2] <= flags_in[ST_RX_BUFFER_FULL_FLAG] & enables_in[ST_RX_BUFFER_FULL_FLAG];
         req_out[3] <= flags_in[ST_STOP] & enables_in[ST_STOP];
         req_out[4] <= (flags_in[ST_NACK] | flags_in[ST_AL]) & enables_in[ST_NACK];
      end
   end
endmodule : ibs_irq

/* hdl/ibs_core.sv */
`timescale 1ns/1ns
// interrupt, bit sync and master-receive hold logic of the bus interface
module ibs_core
   import ibs_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic [3:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic [7:0]      rdata_out,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_out,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   input  wire logic       ev_nack_in,
   input  wire logic       ev_al_in,
   input  wire logic       ev_stop_in,
   output logic            tx_empty_irq_out,
   output logic            tx_end_irq_out,
   output logic            rx_full_irq_out,
   output logic            stop_seen_irq_out,
   output logic            nack_or_arblost_irq_out,
   output logic            irq_out
);
   logic        module_stop;
   logic [4:0]  ctrl;
   logic [7:0]  status;
   logic [4:0]  irq_en;
   logic [7:0]  rx_data_reg;
   logic [7:0]  tx_data;
   logic [7:0]  rx_shift;
   logic [NUM_EV-1:0] ev_status;
   logic [NUM_EV-1:0] ev_enable;
   logic [4:0]  req;
   logic        scl_f;
   logic        sda_f;
   logic        scl_f_d;
   ibs_state_t  state;
   logic [5:0]  cnt;
   logic [3:0]  bit_idx;
   logic        held_once;
   logic        byte_done;
   logic        wr_ok;
   logic        rd_ok;
   logic        rx_read;
   logic        bus_busy;
   logic        scl_low_drv;

   ibs_filter u_scl_filter
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .raw_in     (scl_in),
      .clean_out  (scl_f)
   );
   ibs_filter u_sda_filter
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .raw_in     (sda_in),
      .clean_out  (sda_f)
   );
   ibs_irq u_irq
   (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .flags_in   (status),
      .enables_in (irq_en),
      .req_out    (req)
   );

   // access gating: only the stop register is open while halted
   assign wr_ok   = wr_in & (~module_stop | (addr_in == ADDR_STOP));
   assign rd_ok   = rd_in & (~module_stop | (addr_in == ADDR_STOP));
   assign rx_read = rd_ok & (addr_in == ADDR_RXDATA);
   assign byte_done = scl_f_d & ~scl_f & (bit_idx == 4'(BITS_PER_BYTE));

   // module stop bit, halted out of reset
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         module_stop <= 1'b1;
      else if (wr_in && addr_in == ADDR_STOP)
         module_stop <= wdata_in[0];
   end

   // control and enable registers
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ctrl      <= CTRL_RST;
         irq_en    <= '0;
         ev_enable <= '0;
         tx_data   <= '0;
      end
      else if (wr_ok)
      begin
         if (addr_in == ADDR_CTRL)
            ctrl <= wdata_in[4:0]; // mst and trs land in one write
         else if (addr_in == ADDR_IRQEN)
            irq_en <= wdata_in[4:0];
         else if (addr_in == ADDR_EVEN)
            ev_enable <= wdata_in[NUM_EV-1:0];
         else if (addr_in == ADDR_TXDATA)
            tx_data <= wdata_in;
      end
   end

   // status flags, hardware set wins over software clear
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         status <= STATUS_RST;
      else
      begin
         if (wr_ok && addr_in == ADDR_STATUS)
            status <= status & wdata_in;
         if (wr_ok && addr_in == ADDR_TXDATA)
            status[ST_TX_BUFFER_EMPTY_FLAG] <= 1'b0;
         if (rx_read)
            status[ST_RX_BUFFER_FULL_FLAG] <= 1'b0;
         if (byte_done && ctrl[CTL_MST] && !ctrl[CTL_TRS])
            status[ST_RX_BUFFER_FULL_FLAG] <= 1'b1;
         if (byte_done && ctrl[CTL_TRS])
            status[ST_TX_COMPLETE_FLAG] <= 1'b1;
         if (ev_stop_in)
            status[ST_STOP] <= 1'b1;
         if (ev_nack_in)
            status[ST_NACK] <= 1'b1;
         if (ev_al_in)
            status[ST_AL] <= 1'b1;
      end
   end

   // receive shift and rx data register
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rx_shift    <= '0;
         rx_data_reg <= '0;
      end
      else
      begin
         if (~scl_f_d & scl_f)
            rx_shift <= {rx_shift[6:0], sda_f};
         if (byte_done && !ctrl[CTL_TRS])
            rx_data_reg <= rx_shift;
      end
   end

   // bit sequencer with scl monitoring
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state     <= IBS_IDLE;
         cnt       <= '0;
         held_once <= 1'b0;
         scl_f_d   <= 1'b1;
      end
      else
      begin
         scl_f_d <= scl_f;
         case (state)
            IBS_IDLE:
            begin
               if (ctrl[CTL_MST] && !module_stop)
               begin
                  state <= IBS_LOW;
                  cnt   <= 6'(HALF_BIT_CYC);
               end
            end
            IBS_LOW:
            begin
               if (!ctrl[CTL_MST])
                  state <= IBS_IDLE;
               else if (cnt != '0)
                  cnt <= cnt - 6'd1;
               else if (fall8_pending())
                  state <= IBS_HOLD;
               else
               begin
                  state <= IBS_MON;
                  cnt   <= ibs_mon_cycles({ctrl[CTL_CLOCK_SELECT_BIT3], ctrl[CTL_CLOCK_SELECT_BIT2]});
               end
            end
            IBS_HOLD:
            begin
               // one clock of hold only when the read came near the edge
               if (!status[ST_RX_BUFFER_FULL_FLAG] || held_once)
               begin
                  state     <= IBS_MON;
                  held_once <= 1'b0;
                  cnt       <= ibs_mon_cycles({ctrl[CTL_CLOCK_SELECT_BIT3], ctrl[CTL_CLOCK_SELECT_BIT2]});
               end
            end
            IBS_MON:
            begin
               if (cnt != '0)
                  cnt <= cnt - 6'd1;
               else if (scl_f)
               begin
                  state <= IBS_HIGH; // high count starts on real scl
                  cnt   <= 6'(HALF_BIT_CYC);
               end
            end
            IBS_HIGH:
            begin
               if (cnt != '0)
                  cnt <= cnt - 6'd1;
               else
               begin
                  state <= IBS_LOW;
                  cnt   <= 6'(HALF_BIT_CYC);
               end
            end
            default:
               state <= IBS_IDLE;
         endcase
         if (rx_read && state == IBS_LOW && bit_idx == 4'(BITS_PER_BYTE - 1))
            held_once <= 1'b1; // read racing the eighth fall
      end
   end

   // hold check at the eighth falling edge
   function automatic logic fall8_pending();
      fall8_pending = ctrl[CTL_MST] & ~ctrl[CTL_TRS] & status[ST_RX_BUFFER_FULL_FLAG]
                      & (bit_idx == 4'(BITS_PER_BYTE - 1));
   endfunction : fall8_pending

   // bit counter on filtered scl falls
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         bit_idx <= '0;
      else if (!ctrl[CTL_MST] && !bus_busy)
         bit_idx <= '0;
      else if (scl_f_d & ~scl_f)
         bit_idx <= (bit_idx == 4'(BITS_PER_BYTE)) ? 4'd0 : bit_idx + 4'd1;
   end

   // bus busy set while scl high with sda low, cleared by the stop event input
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         bus_busy <= 1'b0;
      else if (ev_stop_in)
         bus_busy <= 1'b0;
      else if (scl_f && !sda_f)
         bus_busy <= 1'b1;
   end

   // sticky event status for the combined interrupt
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         ev_status <= '0;
      else
      begin
         for (int i = 0; i < NUM_EV; i++)
         begin
            if (req[i])
               ev_status[i] <= 1'b1;
            else if (wr_ok && addr_in == ADDR_EVCLR && wdata_in[i])
               ev_status[i] <= 1'b0;
         end
      end
   end

   // pin drivers: open drain, enable high while pulling low
   assign scl_low_drv = (state == IBS_LOW) || (state == IBS_HOLD);
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         scl_out    <= 1'b0;
         scl_oe_out <= 1'b0;
         sda_out    <= 1'b0;
         sda_oe_out <= 1'b0;
      end
      else
      begin
         scl_out    <= 1'b0;
         scl_oe_out <= scl_low_drv & ~module_stop;
         sda_out    <= 1'b0;
         sda_oe_out <= ctrl[CTL_MST] & ctrl[CTL_TRS] & ~tx_data[7 - bit_idx[2:0]]
                       & ~module_stop & (bit_idx < 4'(BITS_PER_BYTE));
      end
   end

   // interrupt outputs registered
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         tx_empty_irq_out        <= 1'b0;
         tx_end_irq_out          <= 1'b0;
         rx_full_irq_out         <= 1'b0;
         stop_seen_irq_out       <= 1'b0;
         nack_or_arblost_irq_out <= 1'b0;
         irq_out                 <= 1'b0;
      end
      else
      begin
         tx_empty_irq_out        <= req[0];
         tx_end_irq_out          <= req[1];
         rx_full_irq_out         <= req[2];
         stop_seen_irq_out       <= req[3];
         nack_or_arblost_irq_out <= req[4];
         irq_out                 <= |(ev_status & ev_enable);
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rdata_out <= '0;
      else if (!rd_ok)
         rdata_out <= '0;
      else if (addr_in == ADDR_STOP)
         rdata_out <= {7'h00, module_stop};
      else if (addr_in == ADDR_CTRL)
         rdata_out <= {3'h0, ctrl};
      else if (addr_in == ADDR_STATUS)
         rdata_out <= status;
      else if (addr_in == ADDR_IRQEN)
         rdata_out <= {3'h0, irq_en};
      else if (addr_in == ADDR_RXDATA)
         rdata_out <= rx_data_reg;
      else if (addr_in == ADDR_BUSB)
         rdata_out <= {6'h00, bus_busy, scl_f}; // scl monitor bit
      else if (addr_in == ADDR_EVST)
         rdata_out <= {3'h0, ev_status};
      else if (addr_in == ADDR_EVEN)
         rdata_out <= {3'h0, ev_enable};
      else
         rdata_out <= '0;
   end
endmodule : ibs_core

/* tb/ibs_core_properties.sv */
`timescale 1ns/1ns
// port-level checks: halt, irq gating, scl high time
module ibs_core_properties
   import ibs_pkg::*;
(
   input wire logic       sys_clk_in,
   input wire logic       reset_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic       scl_in,
   input wire logic       scl_oe_out,
   input wire logic       ev_nack_in,
   input wire logic       ev_al_in,
   input wire logic       ev_stop_in,
   input wire logic       tx_empty_irq_out,
   input wire logic       tx_end_irq_out,
   input wire logic       rx_full_irq_out,
   input wire logic       stop_seen_irq_out,
   input wire logic       nack_or_arblost_irq_out,
   input wire logic       irq_out
);
   logic       halted;
   logic [4:0] irq_en;
   logic [4:0] ev_en;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // shadow of stop, irq enable and event enable
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         halted <= 1'b1;
         irq_en <= 5'h00;
         ev_en  <= 5'h00;
      end
      else if (wr_in)
      begin
         if (addr_in == ADDR_STOP)
            halted <= wdata_in[0];
         if (!halted && addr_in == ADDR_IRQEN)
            irq_en <= wdata_in[4:0];
         if (!halted && addr_in == ADDR_EVEN)
            ev_en <= wdata_in[4:0];
      end
   end
   // event taken while enable stays set
   sequence s_nack_ev;
      (ev_nack_in || ev_al_in) && irq_en[4] ##1 irq_en[4] [*2];
   endsequence
   sequence s_stop_ev;
      ev_stop_in && irq_en[3] ##1 irq_en[3] [*2];
   endsequence
   property p_halt_read;
      halted && rd_in && addr_in != ADDR_STOP |=> rdata_out == 8'h00;
   endproperty
   property p_tx_mask;
      !irq_en[0] [*3] |-> !tx_empty_irq_out;
   endproperty
   property p_tx_complete_flag_mask;
      !irq_en[1] [*3] |-> !tx_end_irq_out;
   endproperty
   property p_rx_mask;
      !irq_en[2] [*3] |-> !rx_full_irq_out;
   endproperty
   property p_stop_mask;
      !irq_en[3] [*3] |-> !stop_seen_irq_out;
   endproperty
   property p_nack_mask;
      !irq_en[4] [*3] |-> !nack_or_arblost_irq_out;
   endproperty
   property p_nack_set;
      s_nack_ev |-> ##[0:2] nack_or_arblost_irq_out;
   endproperty
   property p_stop_set;
      s_stop_ev |-> ##[0:2] stop_seen_irq_out;
   endproperty
   property p_scl_high;
      $rose(scl_oe_out) |-> $past(scl_in, 4) && $past(scl_in, 8);
   endproperty
   property p_any_mask;
      (ev_en == 5'h00) [*3] |-> !irq_out;
   endproperty
   a_halt_read: assert property (p_halt_read)
      else $error("halted read gave data");
   a_tx_mask: assert property (p_tx_mask)
      else $error("tx empty irq unmasked");
   a_tx_complete_flag_mask: assert property (p_tx_complete_flag_mask)
      else $error("tx end irq unmasked");
   a_rx_mask: assert property (p_rx_mask)
      else $error("rx full irq unmasked");
   a_stop_mask: assert property (p_stop_mask)
      else $error("stop irq unmasked");
   a_nack_mask: assert property (p_nack_mask)
      else $error("nack irq unmasked");
   a_nack_set: assert property (p_nack_set)
      else $error("nack irq missing");
   a_stop_set: assert property (p_stop_set)
      else $error("stop irq missing");
   a_scl_high: assert property (p_scl_high)
      else $error("scl high cut short");
   a_any_mask: assert property (p_any_mask)
      else $error("summary irq unmasked");
endmodule : ibs_core_properties
bind ibs_core ibs_core_properties chk_u (.sys_clk_in, .reset_n_in, .addr_in, .wdata_in,
   .wr_in, .rd_in, .rdata_out, .scl_in, .scl_oe_out, .ev_nack_in, .ev_al_in, .ev_stop_in,
   .tx_empty_irq_out, .tx_end_irq_out, .rx_full_irq_out, .stop_seen_irq_out,
   .nack_or_arblost_irq_out, .irq_out);

/* tb/ibs_bus_slave.sv */
`timescale 1ns/1ns
// far-side slave: sends a fixed byte, stretches scl low after each fall
module ibs_bus_slave
#(
   parameter logic [7:0] TX_BYTE = 8'hA5,
   parameter int         STRETCH = 8
)
(
   input  wire logic sys_clk_in,
   input  wire logic reset_n_in,
   input  wire logic scl_in,
   output logic      scl_pull_out,
   output logic      sda_pull_out
);
   logic       scl_q;
   logic [3:0] slot;
   logic [4:0] hold_cnt;
   // slot 1..8 data bits msb first, 9 is the master's ack
   always_ff @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         scl_q    <= 1'b1;
         slot     <= 4'h0;
         hold_cnt <= 5'h00;
      end
      else
      begin
         scl_q <= scl_in;
         if (scl_q && !scl_in)
         begin
            hold_cnt <= 5'(STRETCH);
            slot     <= (slot == 4'h9) ? 4'h1 : slot + 4'h1;
         end
         else if (hold_cnt != 5'h00)
            hold_cnt <= hold_cnt - 5'h01;
      end
   end
   // open drain pulls; released lines float to the pull-up
   assign scl_pull_out = (hold_cnt != 5'h00);
   assign sda_pull_out = (slot >= 4'h1) && (slot <= 4'h8) && !TX_BYTE[3'(4'h8 - slot)];
endmodule : ibs_bus_slave

/* tb/testbench.sv */
`timescale 1ns/1ns
// self-checking bench for irq, halt and bit sync behaviour
module testbench
   import ibs_pkg::*;
;
   localparam logic [7:0] RX_BYTE  = 8'hA5;
   localparam int         MIN_HIGH = (MON_T00 + 9) / 10;
   logic       clk     = 1'b0;
   logic       rst_n   = 1'b0;
   logic [3:0] addr    = 4'h0;
   logic [7:0] wdata   = 8'h00;
   logic       wr      = 1'b0;
   logic       rd      = 1'b0;
   logic [2:0] ev      = 3'b000;
   logic [7:0] rdata, got;
   logic       scl_oe, sda_oe, scl_pull, sda_pull, scl_w, sda_w;
   logic       tx_irq, tx_complete_flag_irq, rx_irq, stop_irq, nack_irq, any_irq;
   logic [7:0] irq_vec;
   int         err_total   = 0;
   int         checks_done = 0;
   int         hi_run      = 0;
   int         lo_run      = 0;
   always #25 clk = ~clk;
   // wired-and bus with pull-ups
   assign scl_w = ~(scl_oe | scl_pull);
   assign sda_w = ~(sda_oe | sda_pull);
   // request outputs gathered for compares
   assign irq_vec = {3'h0, nack_irq, stop_irq, rx_irq, tx_complete_flag_irq, tx_irq};
   ibs_core dut_u (.sys_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .scl_in(scl_w), .scl_out(),
      .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
      .ev_nack_in(ev[2]), .ev_al_in(ev[1]), .ev_stop_in(ev[0]),
      .tx_empty_irq_out(tx_irq), .tx_end_irq_out(tx_complete_flag_irq), .rx_full_irq_out(rx_irq),
      .stop_seen_irq_out(stop_irq), .nack_or_arblost_irq_out(nack_irq), .irq_out(any_irq));
   ibs_bus_slave #(.TX_BYTE(RX_BYTE), .STRETCH(31)) slave_u (.sys_clk_in(clk),
      .reset_n_in(rst_n), .scl_in(scl_w), .scl_pull_out(scl_pull), .sda_pull_out(sda_pull));
   // scl run lengths; every high run must reach the monitor time
   always @(posedge clk)
   begin
      if (!scl_w && hi_run != 0)
         chk("scl high run", 8'(MIN_HIGH), 8'((hi_run < MIN_HIGH) ? hi_run : MIN_HIGH));
      hi_run <= scl_w ? hi_run + 1 : 0;
      lo_run <= scl_w ? 0 : lo_run + 1;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk
   task automatic pulse(input logic [2:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 3'b000;
   endtask : pulse
   // halted after reset: writes dropped, reads zero
   task automatic t_halt();
      wr_reg(ADDR_IRQEN, 8'h1F);
      rd_reg(ADDR_STATUS, got);
      chk("status halted", 8'h00, got);
      wait_clk(3);
      chk("tx irq halted", 8'h00, {7'h00, tx_irq});
      wr_reg(ADDR_STOP, 8'h00);
      rd_reg(ADDR_STATUS, got);
      chk("status reset", STATUS_RST, got);
      rd_reg(ADDR_IRQEN, got);
      chk("irq enable", 8'h00, got);
      rd_reg(4'hF, got);
      chk("unmapped", 8'h00, got);
      $display("test halt done");
   endtask : t_halt
   // tx empty request follows flag and enable
   task automatic t_tx();
      wr_reg(ADDR_IRQEN, 8'h01);
      wait_clk(3);
      chk("tx irq on", 8'h01, {7'h00, tx_irq});
      wr_reg(ADDR_IRQEN, 8'h00);
      wait_clk(3);
      chk("tx irq masked", 8'h00, {7'h00, tx_irq});
      wr_reg(ADDR_IRQEN, 8'h01);
      wr_reg(ADDR_TXDATA, 8'h3C);
      wait_clk(3);
      chk("tx irq flag gone", 8'h00, {7'h00, tx_irq});
      $display("test tx done");
   endtask : t_tx
   // nack, arbitration lost and stop events, one at a time
   task automatic t_ev();
      logic [2:0] evm [3] = '{3'b100, 3'b010, 3'b001};
      logic [7:0] en  [3] = '{8'h10, 8'h10, 8'h08};
      logic [7:0] stb [3] = '{8'h10, 8'h20, 8'h08};
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(ADDR_IRQEN, en[i]);
         pulse(evm[i]);
         wait_clk(3);
         chk("irq set", en[i], irq_vec);
         rd_reg(ADDR_STATUS, got);
         chk("status flag", stb[i], got);
         wr_reg(ADDR_STATUS, ~stb[i]);
         wait_clk(3);
         chk("irq cleared", 8'h00, irq_vec);
      end
      wr_reg(ADDR_IRQEN, 8'h00);
      wr_reg(ADDR_CTRL, 8'h00); // master and transmit select dropped
      rd_reg(ADDR_CTRL, got);
      chk("mode cleared", 8'h00, got);
      $display("test events done");
   endtask : t_ev
   // summary irq: sticky status, enable, clear
   task automatic t_evirq();
      wr_reg(ADDR_IRQEN, 8'h08); // stop request feeds the sticky bit
      wr_reg(ADDR_EVCLR, 8'hFF);
      wr_reg(ADDR_EVEN, 8'h1F);
      wait_clk(3);
      chk("irq idle", 8'h00, {7'h00, any_irq});
      pulse(3'b001);
      wait_clk(3);
      chk("irq raised", 8'h01, {7'h00, any_irq});
      wr_reg(ADDR_EVEN, 8'h00);
      wait_clk(3);
      chk("irq masked", 8'h00, {7'h00, any_irq});
      wr_reg(ADDR_EVEN, 8'h1F);
      wait_clk(3);
      chk("irq sticky", 8'h01, {7'h00, any_irq});
      wr_reg(ADDR_STATUS, 8'hF7); // stop flag off first, else the set wins
      wr_reg(ADDR_EVCLR, 8'hFF);
      wait_clk(3);
      chk("irq cleared", 8'h00, {7'h00, any_irq});
      $display("test summary irq done");
   endtask : t_evirq
   // master receive against a stretching slave, rx read once at start and again after scl is held
   task automatic t_rx();
      int n;
      wr_reg(ADDR_IRQEN, 8'h04);
      wr_reg(ADDR_CTRL, 8'h05);
      rd_reg(ADDR_RXDATA, got);
      for (n = 0; n < 4000 && rx_irq !== 1'b1; n++)
         @(posedge clk);
      chk("rx irq", 8'h01, {7'h00, rx_irq});
      for (n = 0; n < 4000 && lo_run < 200; n++)
         @(posedge clk);
      chk("scl held", 8'h01, {7'h00, lo_run >= 200});
      rd_reg(ADDR_BUSB, got);
      chk("scl monitor", 8'h00, {7'h00, got[0]});
      rd_reg(ADDR_RXDATA, got);
      chk("rx byte", RX_BYTE, got);
      wait_clk(3);
      chk("rx irq cleared", 8'h00, {7'h00, rx_irq});
      wait_clk(100);
      chk("scl freed", 8'h01, {7'h00, lo_run < 100});
      wr_reg(ADDR_CTRL, 8'h00);
      $display("test master receive done");
   endtask : t_rx
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_halt();
      t_tx();
      t_ev();
      t_evirq();
      t_rx();
      stop_test();
   end
   // watchdog well past the expected run
   initial
   begin
      #(50 * 20000);
      err_total++;
      $display("BAD watchdog expected done seen timeout");
      stop_test();
   end
endmodule : testbench
